// *** rtl/sdc_counter.sv ***
// Six-decade nonvolatile up counter with multiplexed display and APB registers
// Summary of operation
// - Six decimal decades count up by one on each count pulse.
// - A 24-bit nonvolatile store keeps the count.
// - Overflow sets a latch; an extra stored bit keeps it.
// - Save copies counter to store; recall copies store to counter.
// - Digits shown one at a time on seven segments with six strobes.
// - Internal scan oscillator steps digits unless the control register selects the external scan input.
// - Timer mode reads up to 99 hours 59 minutes 59 seconds.
// - Two further timer modes read 9999:59 with tens digit modulo six.
// - Leading zeros may be suppressed and whole display blanked.
module sdc_counter
  import sdc_pkg::*;
#(
  parameter int SAVE_LEN  = SAVE_CYCLES,
  parameter int SCAN_LEN  = SCAN_DIV
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Count and control strobes
  input  wire logic        count_in,
  input  wire logic        save_in,
  input  wire logic        recall_in,
  input  wire logic        scan_in,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Display and interrupt
  output      sdc_disp_t   disp,
  output      logic        overflow,
  output      logic        irq
);

  initial begin
    if (SCAN_LEN < 2) $error("SCAN_LEN must be at least 2");
  end

  // Input edge detection
  logic count_q;
  logic recall_q;
  logic scan_q;
  wire  count_rise  = count_in && !count_q;
  wire  recall_rise = recall_in && !recall_q;
  wire  scan_rise   = scan_in && !scan_q;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_q  <= 1'b0;
      recall_q <= 1'b0;
      scan_q   <= 1'b0;
    end else begin
      count_q  <= count_in;
      recall_q <= recall_in;
      scan_q   <= scan_in;
    end
  end

  // Register bus decode
  logic [31:0]     ctrl;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  wire  access     = psel && penable;
  wire  wr         = access && pwrite;
  wire  rd         = access && !pwrite;
  wire  hit_ctrl   = paddr == ADDR_CTRL;
  wire  hit_count  = paddr == ADDR_COUNT;
  wire  hit_store  = paddr == ADDR_STORE;
  wire  hit_status = paddr == ADDR_STATUS;
  wire  hit_mask   = paddr == ADDR_MASK;
  wire  hit_any    = hit_ctrl | hit_count | hit_store | hit_status | hit_mask;
  wire  sw_save    = wr && hit_store && pwdata[0];
  wire  sw_recall  = wr && hit_store && pwdata[1];

  wire sdc_mode_t  mode      = sdc_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
  wire             lz_en     = ctrl[CTRL_LZ_BIT];
  wire             blank     = ctrl[CTRL_BLANK_BIT];
  wire             ext_scan  = ctrl[CTRL_EXT_BIT];

  // Nonvolatile store
  logic [NV_BITS-1:0] nv_data;
  logic               nv_ovf;
  logic               nv_done;
  logic [NV_BITS-1:0] cnt_bits;
  logic               ovf_latch;

  sdc_nvstore #(
    .SAVE_LEN (SAVE_LEN)
  ) u_store (
    .clock   (clock),
    .rstn    (rstn),
    .save    (save_in || sw_save),
    .wr_data (cnt_bits),
    .wr_ovf  (ovf_latch),
    .data    (nv_data),
    .ovf     (nv_ovf),
    .done    (nv_done)
  );

  // Decade chain
  wire        do_recall = recall_rise || sw_recall;
  logic [3:0] top [DIGITS];
  logic [DIGITS:0] chain;
  assign chain[0] = count_rise;

  // Per-decade modulus; decade 0 is least significant
  always_comb begin
    for (int i = 0; i < DIGITS; i++) begin
      top[i] = 4'h9;
    end
    case (mode)
      SDC_HMS: begin
        top[1] = 4'h5;
        top[3] = 4'h5;
      end
      SDC_HM, SDC_MS: begin
        top[1] = 4'h5;
      end
      default: begin
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_dec
      sdc_decade u_dec (
        .clock    (clock),
        .rstn     (rstn),
        .inc      (chain[g]),
        .load     (do_recall),
        .load_val (nv_data[4*g +: 4]),
        .top      (top[g]),
        .value    (cnt_bits[4*g +: 4]),
        .carry    (chain[g+1])
      );
    end
  endgenerate

  // Overflow latch
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovf_latch <= 1'b0;
    end else if (chain[DIGITS]) begin
      ovf_latch <= 1'b1;
    end else if (do_recall) begin
      ovf_latch <= nv_ovf;
    end
  end

  // Scan timing
  logic [31:0]        scan_cnt;
  logic [2:0]         digit;
  wire                int_tick = (scan_cnt == 32'(SCAN_LEN - 1));
  wire                step     = ext_scan ? scan_rise : int_tick;
  wire  [2:0]         next_digit = (digit == 3'(DIGITS - 1)) ? 3'h0 : digit + 3'h1;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      scan_cnt <= 32'h0000_0000;
      digit    <= 3'h0;
    end else begin
      scan_cnt <= int_tick ? 32'h0000_0000 : scan_cnt + 32'h0000_0001;
      if (step) begin
        digit <= next_digit;
      end
    end
  end

  // Leading-zero map: digit i above 0 is leading if it and all above are zero; digit 0 never is
  logic [DIGITS-1:0] lead;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_lead
      if (g == DIGITS - 1) begin : g_top
        assign lead[g] = cnt_bits[4*g +: 4] == 4'h0;
      end else begin : g_rest
        assign lead[g] = (cnt_bits[4*g +: 4] == 4'h0) && lead[g+1] && (g != 0);
      end
    end
  endgenerate

  wire  [3:0] cur_val = cnt_bits[4*digit +: 4];
  logic [6:0] seg_code;

  // Segment order gfedcba
  always_comb begin
    case (cur_val)
      4'h0:    seg_code = 7'h3f;
      4'h1:    seg_code = 7'h06;
      4'h2:    seg_code = 7'h5b;
      4'h3:    seg_code = 7'h4f;
      4'h4:    seg_code = 7'h66;
      4'h5:    seg_code = 7'h6d;
      4'h6:    seg_code = 7'h7d;
      4'h7:    seg_code = 7'h07;
      4'h8:    seg_code = 7'h7f;
      4'h9:    seg_code = 7'h6f;
      default: seg_code = 7'h00;
    endcase
  end

  wire suppress = blank || (lz_en && lead[digit]);
  wire [DIGITS-1:0] strobe_sel = DIGITS'(1) << digit;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      disp     <= '0;
      overflow <= 1'b0;
    end else begin
      disp.seg    <= suppress ? 7'h00 : seg_code;
      disp.strobe <= blank ? '0 : strobe_sel;
      overflow    <= ovf_latch;
    end
  end

  // Status events; set wins over read-clear
  wire [ST_W-1:0] events;
  assign events[ST_OVF]      = chain[DIGITS];
  assign events[ST_SAVED]    = nv_done;
  assign events[ST_RECALLED] = do_recall;
  wire            st_clr     = rd && hit_status;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)   rd_mux = ctrl;
    if (hit_count)  rd_mux = {7'h00, ovf_latch, cnt_bits};
    if (hit_store)  rd_mux = {7'h00, nv_ovf, nv_data};
    if (hit_status) rd_mux = {29'h0000_0000, status};
    if (hit_mask)   rd_mux = {29'h0000_0000, mask};
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl    <= CTRL_RESET;
      mask    <= '0;
      status  <= '0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      if (wr && hit_ctrl) ctrl <= {27'h000_0000, pwdata[4:0]};
      if (wr && hit_mask) mask <= pwdata[ST_W-1:0];
      status  <= (st_clr ? '0 : status) | events;
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      irq     <= |(((st_clr ? '0 : status) | events) & mask);
    end
  end

endmodule

// *** rtl/sdc_decade.sv ***
// One counting decade with selectable modulus
module sdc_decade (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Control
  input  wire logic       inc,
  input  wire logic       load,
  input  wire logic [3:0] load_val,
  input  wire logic [3:0] top,
  // State
  output      logic [3:0] value,
  output      logic       carry
);

  assign carry = inc && (value == top);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      value <= 4'h0;
    end else if (load) begin
      value <= load_val;
    end else if (inc) begin
      value <= carry ? 4'h0 : value + 4'h1;
    end
  end

endmodule

// *** rtl/sdc_nvstore.sv ***
// Nonvolatile store: 24 count bits plus overflow bit, timed save
module sdc_nvstore
  import sdc_pkg::*;
#(
  parameter int SAVE_LEN = SAVE_CYCLES
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Control
  input  wire logic               save,
  input  wire logic [NV_BITS-1:0] wr_data,
  input  wire logic               wr_ovf,
  // Stored contents
  output      logic [NV_BITS-1:0] data,
  output      logic               ovf,
  output      logic               done
);

  initial begin
    if (SAVE_LEN < 2) $error("SAVE_LEN must be at least 2");
  end

  logic [31:0] hold;
  wire         full = (hold == 32'(SAVE_LEN - 1));

  // Data commits only once save has been held for SAVE_LEN - 1 cycles
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hold <= 32'h0000_0000;
      done <= 1'b0;
    end else begin
      hold <= (save && !full) ? hold + 32'h0000_0001 : (save ? hold : 32'h0000_0000);
      done <= save && (hold == 32'(SAVE_LEN - 2));
    end
  end

  // Contents kept across the counter reset, as in retention
  always_ff @(posedge clock) begin
    if (save && hold == 32'(SAVE_LEN - 2)) begin
      data <= wr_data;
      ovf  <= wr_ovf;
    end
  end

endmodule

// *** shared/sdc_pkg.sv ***
// Shared constants, types and register map of the six-decade counter
package sdc_pkg;

  localparam int          DIGITS         = 6;
  localparam int          NV_BITS        = 24;
  localparam logic [31:0] SAVE_TIME_MS   = 32'h0000_000a;
  localparam int          CLOCK_MHZ      = 200;
  localparam int          SAVE_CYCLES    = 10 * 1000 * CLOCK_MHZ;
  localparam int          SCAN_DIV       = 1024;

  // APB register byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_COUNT     = 8'h04;
  localparam logic [7:0]  ADDR_STORE     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
  localparam logic [7:0]  ADDR_MASK      = 8'h10;

  // Control register fields
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_LZ_BIT    = 2;
  localparam int          CTRL_BLANK_BIT = 3;
  localparam int          CTRL_EXT_BIT   = 4;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Status bits
  localparam int          ST_OVF         = 0;
  localparam int          ST_SAVED       = 1;
  localparam int          ST_RECALLED    = 2;
  localparam int          ST_W           = 3;

  typedef enum logic [1:0] {
    SDC_DECIMAL,
    SDC_HMS,
    SDC_HM,
    SDC_MS
  } sdc_mode_t;

  typedef struct packed {
    logic [6:0]        seg;
    logic [DIGITS-1:0] strobe;
  } sdc_disp_t;

endpackage

// *** tb/sdc_counter_asserts.sv ***
// Port checker: scan order, bus answer, overflow latch
module sdc_counter_asserts
  import sdc_pkg::*;
#(
  parameter int SCAN_LEN = SCAN_DIV
) (
  // Watched ports
  input wire logic      clock,
  input wire logic      rstn,
  input wire logic      recall_in,
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pready,
  input wire logic      pslverr,
  input wire sdc_disp_t disp,
  input wire logic      overflow,
  input wire logic      irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] prev;
  int         since;
  wire        step = disp.strobe != 0 && prev != 0 && disp.strobe != prev;

  always_ff @(posedge clock) begin
    prev  <= disp.strobe;
    since <= (!rstn || disp.strobe != prev) ? 0 : since + 1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_strobe_onehot: assert property ($onehot0(disp.strobe))
    else $error("strobes not one-hot");
  a_strobe_order: assert property (step |->
    disp.strobe == {prev[4:0], prev[5]})
    else $error("strobe skipped a digit");
  a_scan_spacing: assert property (step |-> since >= SCAN_LEN - 1)
    else $error("digit stepped early");
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no bus answer");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ovf_hold: assert property (
    overflow && !recall_in && !$past(recall_in) |=> overflow)
    else $error("overflow latch dropped");
  a_reset_quiet: assert property (
    $rose(rstn) |-> !overflow && !irq && disp.strobe == 0)
    else $error("outputs not cleared");
endmodule

bind sdc_counter sdc_counter_asserts #(.SCAN_LEN(SCAN_LEN)) sdc_counter_asserts_i (
  .clock(clock), .rstn(rstn), .recall_in(recall_in), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .disp(disp), .overflow(overflow), .irq(irq));

// *** tb/sdc_display.sv ***
// Display model: keeps the segments last shown at each digit
module sdc_display
  import sdc_pkg::*;
(
  // Display pins
  input  wire logic      clock,
  input  wire sdc_disp_t disp,
  // Digit images
  output logic [6:0]     shown [DIGITS]
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clock)
    for (int i = 0; i < DIGITS; i++)
      if (disp.strobe[i]) shown[i] <= disp.seg;
endmodule

// *** tb/tb_sdc_counter.sv ***
// Bench for the six-decade counter
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module tb_sdc_counter import sdc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [1:0]  mode;
    int          n;
    logic [23:0] cnt;
  } sdc_row_t;
  sdc_row_t    rows [6] = '{'{2'h1, 60, 24'h00_0100}, '{2'h2, 60, 24'h00_0100},
                            '{2'h3, 60, 24'h00_0100}, '{2'h1, 3600, 24'h01_0000},
                            '{2'h0, 60, 24'h00_0060}, '{2'h0, 12, 24'h00_0012}};
  logic        clock, rstn, count_in, save_in, recall_in, scan_in;
  logic        psel, penable, pwrite, pready, pslverr, overflow, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  s;
  logic [6:0]  shown [DIGITS];
  sdc_disp_t   disp;
  int          k;
  int          n_mismatch = 0;
  int          n_checks = 0;

  sdc_counter #(.SAVE_LEN(8), .SCAN_LEN(4)) sdc_counter_i (
    .clock(clock), .rstn(rstn), .count_in(count_in), .save_in(save_in),
    .recall_in(recall_in), .scan_in(scan_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .disp(disp), .overflow(overflow), .irq(irq));
  sdc_display sdc_display_i (.clock(clock), .disp(disp), .shown(shown));

  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end

  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      n_mismatch++;
      final_report();
    end
    @(posedge clock);
  endtask

  task automatic pulses(int n);
    repeat (n) begin
      count_in <= 1'b1;
      tick(2);
      count_in <= 1'b0;
      tick(2);
    end
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    tick(3);
    rstn <= 1'b1;
    tick(1);
  endtask

  initial begin
    {count_in, save_in, recall_in, scan_in, psel, penable, pwrite} <= '0;
    paddr  <= 8'h00;
    pwdata <= 32'h0000_0000;
    do_reset();
    apb(0, ADDR_CTRL, 32'h0);
    `CHK(rd, CTRL_RESET)
    foreach (rows[j]) begin
      do_reset();
      apb(1, ADDR_CTRL, {30'h0, rows[j].mode});
      pulses(rows[j].n);
      apb(0, ADDR_COUNT, 32'h0);
      `CHK(rd, {8'h00, rows[j].cnt})
      `CHK(overflow, 1'b0)
    end
    // Full save, then a short one that must not commit
    save_in <= 1'b1;
    tick(8);
    save_in <= 1'b0;
    tick(3);
    `CHK(irq, 1'b0)
    apb(0, ADDR_STORE, 32'h0);
    `CHK(rd, 32'h0000_0012)
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0002)
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0000)
    pulses(5);
    save_in <= 1'b1;
    tick(3);
    save_in <= 1'b0;
    apb(0, ADDR_STORE, 32'h0);
    `CHK(rd, 32'h0000_0012)
    apb(1, ADDR_MASK, 32'h0000_0004);
    recall_in <= 1'b1;
    tick(4);
    recall_in <= 1'b0;
    tick(3);
    `CHK(irq, 1'b1)
    apb(0, ADDR_COUNT, 32'h0);
    `CHK(rd, 32'h0000_0012)
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0004)
    tick(2);
    `CHK(irq, 1'b0)
    // Software recall through the store register
    pulses(3);
    apb(1, ADDR_STORE, 32'h0000_0002);
    apb(0, ADDR_COUNT, 32'h0);
    `CHK(rd, 32'h0000_0012)
    apb(0, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    tick(60);
    `CHK(shown[0], 7'h5b)
    `CHK(shown[1], 7'h06)
    `CHK(shown[5], 7'h3f)
    apb(1, ADDR_CTRL, 32'h0000_0004);
    k = 0;
    repeat (40) begin
      tick(1);
      if (disp.strobe[5] === 1'b1 && disp.seg !== 7'h00) k++;
    end
    `CHK(k, 0)
    apb(1, ADDR_CTRL, 32'h0000_0010);
    tick(8);
    s = disp.strobe;
    scan_in <= 1'b1;
    tick(4);
    scan_in <= 1'b0;
    tick(20);
    `CHK(disp.strobe, {s[4:0], s[5]})
    apb(1, ADDR_CTRL, 32'h0000_0008);
    tick(3);
    `CHK(disp.strobe, 6'h00)
    final_report();
  end
endmodule
